// ==== rxpc_map.svh ====
// register offsets, reset values, field positions and frame constants
`ifndef RXPC_MAP_SVH
`define RXPC_MAP_SVH

// ==========
// register offsets
`define RXPC_OFS_RSVD_A   5'h13
`define RXPC_OFS_RSSI     5'h14
`define RXPC_OFS_OOK      5'h15
`define RXPC_OFS_SYNC3    5'h16
`define RXPC_OFS_SYNC2    5'h17
`define RXPC_OFS_SYNC1    5'h18
`define RXPC_OFS_SYNC0    5'h19
`define RXPC_OFS_CLKOUT   5'h1b
`define RXPC_OFS_PKTLEN   5'h1c
`define RXPC_OFS_NODE     5'h1d
`define RXPC_OFS_PKTFMT   5'h1e
`define RXPC_OFS_CRCCLR   5'h1f

// ==========
// reset values
`define RXPC_RST_RSVD_A   8'h07
`define RXPC_RST_OOK      8'h00
`define RXPC_RST_SYNC     8'h00
`define RXPC_RST_CLKOUT   8'hbc
`define RXPC_RST_PKTLEN   8'h00
`define RXPC_RST_NODE     8'h00
`define RXPC_RST_PKTFMT   7'h24
`define RXPC_RST_CRCCLR   8'h00

// ==========
// field positions
`define RXPC_F_STEP       7:5
`define RXPC_F_DECPER     4:2
`define RXPC_F_CUTOFF     1:0
`define RXPC_F_CLKON      7
`define RXPC_F_CLKDIV     6:2
`define RXPC_F_MANCH      7
`define RXPC_F_LEN        6:0
`define RXPC_F_VARLEN     7
`define RXPC_F_WHITE      4
`define RXPC_F_CRCON      3
`define RXPC_F_AFILT      2:1
`define RXPC_F_AUTOCLR    7

// ==========
// serial frame, dewhitening and threshold timing
`define RXPC_HDR_LAST     4'h7
`define RXPC_FRAME_LAST   4'hf
`define RXPC_PN9_SEED     9'h1ff
`define RXPC_SUBTICKS     8'h10

`endif

// ==== rxpc_pkg.sv ====
// types shared by the receiver configuration register block
package rxpc_pkg;
    typedef enum logic [2:0] {
        RXPC_IDLE = 3'b001,
        RXPC_HEAD = 3'b010,
        RXPC_DATA = 3'b100
    } rxpc_spi_e;
endpackage

// ==== rxpc_config_regs.sv ====
// receiver configuration and status registers behind the serial config port
//
// Contract
// - signal strength, 8 bits, half dB per count; read only.
// - step codes 0-3 give 0.5-2 dB, 4-7 give 3-6 dB.
// - decrement once per 1-8 chips or 2-16 times per chip.
// - cutoff 00 is BR/8pi, 11 is BR/32pi; others reserved.
// - sync bytes MSB first, used per sync size code.
// - bit 7 enables clock output; resets enabled.
// - divider 0 passes crystal, else divides by twice; reset 01111.
// - length register bit 7 enables Manchester decoding; resets off.
// - fixed format: length field is exact payload length.
// - variable format: length field is maximum payload length.
// - eight-bit node address, reset zero, used by filtering.
// - filter 00 off, 01 node, 10 adds 00, 11 adds ff.
// - read-only bit 0 is 1 when current packet CRC passes.
// - auto-clear bit at 0 clears FIFO on CRC fail.
// - sync size codes 00 to 11 select 8 to 32 bits.
`timescale 1ns/10ps
`include "rxpc_map.svh"

module rxpc_config_regs (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // serial configuration port pins
    input  wire logic        cfgSelN,
    input  wire logic        cfgSck,
    input  wire logic        cfgMosi,
    output logic             cfgMiso,
    output logic             cfgMisoOeN,
    // receiver datapath status in
    input  wire logic [7:0]  rssiLevel,
    input  wire logic [1:0]  syncSize,
    input  wire logic        subChipTick,
    input  wire logic        rxStart,
    input  wire logic        rxAddrValid,
    input  wire logic [7:0]  rxAddr,
    input  wire logic        rxLenValid,
    input  wire logic [7:0]  rxLen,
    input  wire logic        rxDataValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        crcDone,
    input  wire logic        crcOk,
    // demodulator controls
    output logic [3:0]       thrStepHalfDb,
    output logic             thrDecPulse,
    output logic             avgSlowCutoff,
    output logic [31:0]      syncPattern,
    output logic [31:0]      syncMask,
    // clock output pin
    output logic             clkOut,
    output logic             clkOutEnable,
    output logic             clkOutBypass,
    // packet handler
    output logic             manchesterEnable,
    output logic             fixedLength,
    output logic [6:0]       lengthLimit,
    output logic             lengthOk,
    output logic             addrAccept,
    output logic [7:0]       rxDataOut,
    output logic             rxDataOutValid,
    output logic             crcCheckEnable,
    output logic             fifoClear
);

    // ==========
    // pin synchronisers
    logic [2:0] selSync, sckSync;
    logic [1:0] mosiSync;
    logic       selS, sckS, mosiS, sckRise, sckFall;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selSync  <= 3'h7;
            sckSync  <= 3'h0;
            mosiSync <= 2'h0;
        end else begin
            selSync  <= {selSync[1:0], cfgSelN};
            sckSync  <= {sckSync[1:0], cfgSck};
            mosiSync <= {mosiSync[0], cfgMosi};
        end
    end

    assign selS    = selSync[1];
    assign sckS    = sckSync[1];
    assign mosiS   = mosiSync[1];
    assign sckRise = sckS & ~sckSync[2];
    assign sckFall = ~sckS & sckSync[2];

    // ==========
    // register storage
    logic [7:0] rsvdA, rssiReg, ookCtl, pktLenCtl, nodeAddr, clrCtl, clkCtl;
    logic [7:0] syncB [4];
    logic [6:0] fmtCtl;
    logic       crcStatus;

    function automatic logic [7:0] readReg(input logic [4:0] a);
        case (a)
            `RXPC_OFS_RSVD_A: readReg = rsvdA;
            `RXPC_OFS_RSSI:   readReg = rssiReg;
            `RXPC_OFS_OOK:    readReg = ookCtl;
            `RXPC_OFS_SYNC3:  readReg = syncB[3];
            `RXPC_OFS_SYNC2:  readReg = syncB[2];
            `RXPC_OFS_SYNC1:  readReg = syncB[1];
            `RXPC_OFS_SYNC0:  readReg = syncB[0];
            `RXPC_OFS_CLKOUT: readReg = clkCtl;
            `RXPC_OFS_PKTLEN: readReg = pktLenCtl;
            `RXPC_OFS_NODE:   readReg = nodeAddr;
            `RXPC_OFS_PKTFMT: readReg = {fmtCtl, crcStatus};
            `RXPC_OFS_CRCCLR: readReg = clrCtl;
            default:          readReg = 8'h00;
        endcase
    endfunction

    // ==========
    // serial frame: start, rw, 5-bit address, stop, then 8 data bits
    rxpc_pkg::rxpc_spi_e state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] rxShift, next_rxShift, txShift, next_txShift;
    logic [4:0] regAddr, next_regAddr;
    logic       isRead, next_isRead, next_cfgMiso, next_cfgMisoOeN;
    logic       wrEn, next_wrEn;
    logic [7:0] wrData, next_wrData;

    always_comb begin
        next_state      = state;
        next_bitCnt     = bitCnt;
        next_rxShift    = rxShift;
        next_txShift    = txShift;
        next_regAddr    = regAddr;
        next_isRead     = isRead;
        next_cfgMiso    = cfgMiso;
        next_wrEn       = 1'b0;
        next_wrData     = wrData;
        case (state)
            rxpc_pkg::RXPC_IDLE: begin
                next_bitCnt = 4'h0;
                if (!selS) begin
                    next_state = rxpc_pkg::RXPC_HEAD;
                end
            end
            rxpc_pkg::RXPC_HEAD: begin
                if (sckRise) begin
                    next_rxShift = {rxShift[6:0], mosiS};
                    next_bitCnt  = bitCnt + 4'h1;
                    if (bitCnt == `RXPC_HDR_LAST) begin
                        next_isRead  = rxShift[5];
                        next_regAddr = rxShift[4:0];
                        next_txShift = readReg(rxShift[4:0]);
                        next_state   = rxpc_pkg::RXPC_DATA;
                    end
                end
            end
            rxpc_pkg::RXPC_DATA: begin
                if (sckFall) begin
                    next_cfgMiso = txShift[7];
                    next_txShift = {txShift[6:0], 1'b0};
                end
                if (sckRise) begin
                    next_rxShift = {rxShift[6:0], mosiS};
                    next_bitCnt  = bitCnt + 4'h1;
                    if (bitCnt == `RXPC_FRAME_LAST) begin
                        next_wrEn   = ~isRead;
                        next_wrData = {rxShift[6:0], mosiS};
                        next_state  = rxpc_pkg::RXPC_HEAD;
                    end
                end
            end
            default: next_state = rxpc_pkg::RXPC_IDLE;
        endcase
        if (selS) begin
            next_state = rxpc_pkg::RXPC_IDLE;
        end
        next_cfgMisoOeN = ~((next_state == rxpc_pkg::RXPC_DATA) & next_isRead);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= rxpc_pkg::RXPC_IDLE;
            bitCnt     <= 4'h0;
            rxShift    <= 8'h00;
            txShift    <= 8'h00;
            regAddr    <= 5'h00;
            isRead     <= 1'b0;
            cfgMiso    <= 1'b0;
            cfgMisoOeN <= 1'b1;
            wrEn       <= 1'b0;
            wrData     <= 8'h00;
        end else begin
            state      <= next_state;
            bitCnt     <= next_bitCnt;
            rxShift    <= next_rxShift;
            txShift    <= next_txShift;
            regAddr    <= next_regAddr;
            isRead     <= next_isRead;
            cfgMiso    <= next_cfgMiso;
            cfgMisoOeN <= next_cfgMisoOeN;
            wrEn       <= next_wrEn;
            wrData     <= next_wrData;
        end
    end

    // ==========
    // register writes and packet status
    logic [7:0] next_rsvdA, next_ookCtl, next_pktLenCtl, next_nodeAddr, next_clrCtl, next_clkCtl;
    logic [7:0] next_syncB [4];
    logic [6:0] next_fmtCtl;
    logic       next_crcStatus, next_fifoClear;

    always_comb begin
        next_rsvdA     = rsvdA;
        next_ookCtl    = ookCtl;
        next_syncB     = syncB;
        next_clkCtl    = clkCtl;
        next_pktLenCtl = pktLenCtl;
        next_nodeAddr  = nodeAddr;
        next_fmtCtl    = fmtCtl;
        next_clrCtl    = clrCtl;
        next_crcStatus = crcStatus;
        next_fifoClear = 1'b0;
        if (wrEn) begin
            case (regAddr)
                `RXPC_OFS_RSVD_A: next_rsvdA     = wrData;
                `RXPC_OFS_OOK:    next_ookCtl    = wrData;
                `RXPC_OFS_SYNC3:  next_syncB[3]  = wrData;
                `RXPC_OFS_SYNC2:  next_syncB[2]  = wrData;
                `RXPC_OFS_SYNC1:  next_syncB[1]  = wrData;
                `RXPC_OFS_SYNC0:  next_syncB[0]  = wrData;
                `RXPC_OFS_CLKOUT: next_clkCtl    = wrData;
                `RXPC_OFS_PKTLEN: next_pktLenCtl = wrData;
                `RXPC_OFS_NODE:   next_nodeAddr  = wrData;
                `RXPC_OFS_PKTFMT: next_fmtCtl    = wrData[7:1];
                `RXPC_OFS_CRCCLR: next_clrCtl    = wrData;
                default: ;
            endcase
        end
        // check skipped entirely while disabled
        if (crcDone && fmtCtl[`RXPC_F_CRCON - 1]) begin
            next_crcStatus = crcOk;
            next_fifoClear = ~crcOk & ~clrCtl[`RXPC_F_AUTOCLR];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsvdA     <= `RXPC_RST_RSVD_A;
            rssiReg   <= 8'h00;
            ookCtl    <= `RXPC_RST_OOK;
            syncB     <= '{default: `RXPC_RST_SYNC};
            clkCtl    <= `RXPC_RST_CLKOUT;
            pktLenCtl <= `RXPC_RST_PKTLEN;
            nodeAddr  <= `RXPC_RST_NODE;
            fmtCtl    <= `RXPC_RST_PKTFMT;
            clrCtl    <= `RXPC_RST_CRCCLR;
            crcStatus <= 1'b0;
            fifoClear <= 1'b0;
        end else begin
            rsvdA     <= next_rsvdA;
            rssiReg   <= rssiLevel;
            ookCtl    <= next_ookCtl;
            syncB     <= next_syncB;
            clkCtl    <= next_clkCtl;
            pktLenCtl <= next_pktLenCtl;
            nodeAddr  <= next_nodeAddr;
            fmtCtl    <= next_fmtCtl;
            clrCtl    <= next_clrCtl;
            crcStatus <= next_crcStatus;
            fifoClear <= next_fifoClear;
        end
    end

    // ==========
    // derived controls, threshold timing, clock output, packet checks
    logic [2:0]  stepCode, perCode;
    logic [4:0]  clkDiv, next_clkDivCnt, clkDivCnt;
    logic [7:0]  decInterval, decCnt, next_decCnt;
    logic [8:0]  pn9, next_pn9;
    logic [7:0]  next_rxDataOut, wMask;
    logic [31:0] next_syncMask;
    logic        next_clkOut, next_thrDecPulse, next_lengthOk, next_addrAccept, next_rxDataOutValid;

    assign stepCode = ookCtl[`RXPC_F_STEP];
    assign perCode  = ookCtl[`RXPC_F_DECPER];
    assign clkDiv   = clkCtl[`RXPC_F_CLKDIV];

    function automatic logic [16:0] pn9Byte(input logic [8:0] s);
        logic [8:0] st;
        logic [7:0] m;
        st = s;
        m  = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = st[0];
            st   = {st[0] ^ st[5], st[8:1]};
        end
        pn9Byte = {m, st};
    endfunction

    always_comb begin
        // sub-chip ticks: 16 per chip
        if (perCode[2]) begin
            decInterval = `RXPC_SUBTICKS >> ({1'b0, perCode[1:0]} + 3'h1);
        end else begin
            decInterval = `RXPC_SUBTICKS << perCode[1:0];
        end
        next_decCnt      = decCnt;
        next_thrDecPulse = 1'b0;
        if (subChipTick) begin
            if (decCnt >= decInterval - 8'h01) begin
                next_decCnt      = 8'h00;
                next_thrDecPulse = 1'b1;
            end else begin
                next_decCnt = decCnt + 8'h01;
            end
        end
        // toggling every clkDiv cycles gives crystal over 2*clkDiv
        next_clkDivCnt = clkDivCnt + 5'h01;
        next_clkOut    = clkOut;
        if (!clkCtl[`RXPC_F_CLKON] || clkDiv == 5'h00) begin
            next_clkDivCnt = 5'h00;
            next_clkOut    = 1'b0;
        end else if (clkDivCnt >= clkDiv - 5'h01) begin
            next_clkDivCnt = 5'h00;
            next_clkOut    = ~clkOut;
        end
        case (syncSize)
            2'b00:   next_syncMask = 32'hff000000;
            2'b01:   next_syncMask = 32'hffff0000;
            2'b10:   next_syncMask = 32'hffffff00;
            default: next_syncMask = 32'hffffffff;
        endcase
        next_lengthOk = lengthOk;
        if (rxLenValid) begin
            if (fmtCtl[`RXPC_F_VARLEN - 1]) begin
                next_lengthOk = rxLen <= {1'b0, pktLenCtl[`RXPC_F_LEN]};
            end else begin
                next_lengthOk = rxLen == {1'b0, pktLenCtl[`RXPC_F_LEN]};
            end
        end
        next_addrAccept = addrAccept;
        if (rxAddrValid) begin
            case (fmtCtl[1:0])
                2'b00:   next_addrAccept = 1'b1;
                2'b01:   next_addrAccept = rxAddr == nodeAddr;
                2'b10:   next_addrAccept = rxAddr == nodeAddr || rxAddr == 8'h00;
                default: next_addrAccept = rxAddr == nodeAddr || rxAddr == 8'h00 || rxAddr == 8'hff;
            endcase
        end
        {wMask, next_pn9}   = pn9Byte(pn9);
        next_rxDataOut      = rxData;
        next_rxDataOutValid = rxDataValid;
        if (rxStart) begin
            next_pn9 = `RXPC_PN9_SEED;
        end else if (!rxDataValid) begin
            next_pn9 = pn9;
        end else if (fmtCtl[`RXPC_F_WHITE - 1]) begin
            next_rxDataOut = rxData ^ wMask;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            decCnt           <= 8'h00;
            thrDecPulse      <= 1'b0;
            thrStepHalfDb    <= 4'h1;
            avgSlowCutoff    <= 1'b0;
            syncPattern      <= 32'h00000000;
            syncMask         <= 32'hffffffff;
            clkDivCnt        <= 5'h00;
            clkOut           <= 1'b0;
            clkOutEnable     <= 1'b1;
            clkOutBypass     <= 1'b0;
            manchesterEnable <= 1'b0;
            fixedLength      <= 1'b1;
            lengthLimit      <= 7'h00;
            lengthOk         <= 1'b0;
            addrAccept       <= 1'b0;
            pn9              <= `RXPC_PN9_SEED;
            rxDataOut        <= 8'h00;
            rxDataOutValid   <= 1'b0;
            crcCheckEnable   <= 1'b1;
        end else begin
            decCnt           <= next_decCnt;
            thrDecPulse      <= next_thrDecPulse;
            thrStepHalfDb    <= stepCode[2] ? {stepCode, 1'b0} - 4'h2 : {1'b0, stepCode} + 4'h1;
            avgSlowCutoff    <= ookCtl[`RXPC_F_CUTOFF] == 2'b11;
            syncPattern      <= {syncB[3], syncB[2], syncB[1], syncB[0]};
            syncMask         <= next_syncMask;
            clkDivCnt        <= next_clkDivCnt;
            clkOut           <= next_clkOut;
            clkOutEnable     <= clkCtl[`RXPC_F_CLKON];
            clkOutBypass     <= clkDiv == 5'h00;
            manchesterEnable <= pktLenCtl[`RXPC_F_MANCH];
            fixedLength      <= ~fmtCtl[`RXPC_F_VARLEN - 1];
            lengthLimit      <= pktLenCtl[`RXPC_F_LEN];
            lengthOk         <= next_lengthOk;
            addrAccept       <= next_addrAccept;
            pn9              <= next_pn9;
            rxDataOut        <= next_rxDataOut;
            rxDataOutValid   <= next_rxDataOutValid;
            crcCheckEnable   <= fmtCtl[`RXPC_F_CRCON - 1];
        end
    end

endmodule

// ==== rxpc_host_model.sv ====
// host model driving the serial configuration port of the register block
`timescale 1ns/10ps

module rxpc_host_model (
    // clock
    input  wire logic core_clk,
    // serial port
    output logic      cfgSelN,
    output logic      cfgSck,
    output logic      cfgMosi,
    input  wire logic cfgMiso
);
    initial {cfgSelN, cfgSck, cfgMosi} = 3'b100;

    // ==========
    // one frame: header then data, msb first, phases of 6 and 5 clocks
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {1'b0, rd, a, 1'b0, d};
        q = 8'h00;
        @(posedge core_clk);
        cfgSelN <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            cfgMosi <= f[i];
            repeat (5) @(posedge core_clk);
            @(negedge core_clk);
            if (i < 8) q[i] = cfgMiso;
            @(posedge core_clk);
            cfgSck <= 1'b1;
            repeat (5) @(posedge core_clk);
            cfgSck <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
        cfgSelN <= 1'b1;
        cfgMosi <= ~cfgMosi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

// ==== rxpc_config_regs_chk.sv ====
// port assertions for the receiver configuration register block
`timescale 1ns/10ps

module rxpc_config_regs_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // inputs
    input wire logic        cfgSelN,
    input wire logic [1:0]  syncSize,
    input wire logic        rxAddrValid,
    input wire logic        rxLenValid,
    input wire logic [7:0]  rxLen,
    input wire logic        rxDataValid,
    input wire logic        crcDone,
    input wire logic        crcOk,
    // outputs
    input wire logic        cfgMisoOeN,
    input wire logic [3:0]  thrStepHalfDb,
    input wire logic [31:0] syncMask,
    input wire logic        clkOut,
    input wire logic        clkOutEnable,
    input wire logic        clkOutBypass,
    input wire logic        fixedLength,
    input wire logic [6:0]  lengthLimit,
    input wire logic        lengthOk,
    input wire logic        addrAccept,
    input wire logic        rxDataOutValid,
    input wire logic        crcCheckEnable,
    input wire logic        fifoClear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========
    // assertions
    a_step_code_set: assert property (thrStepHalfDb inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc})
        else $error("step off coded set");
    a_sync_mask_size: assert property (syncSize == $past(syncSize) |->
        syncMask == {8'hff, {8{syncSize != 2'h0}}, {8{syncSize[1]}}, {8{syncSize == 2'h3}}})
        else $error("sync mask wrong");
    a_fixed_len_eq: assert property (rxLenValid && fixedLength |=> lengthOk == ($past(rxLen) == {1'b0, $past(lengthLimit)}))
        else $error("fixed length wrong");
    a_var_len_max: assert property (rxLenValid && !fixedLength |=> lengthOk == ($past(rxLen) <= {1'b0, $past(lengthLimit)}))
        else $error("max length wrong");
    a_len_verdict_hold: assert property (!rxLenValid |=> $stable(lengthOk))
        else $error("length verdict moved");
    a_addr_verdict_hold: assert property (!rxAddrValid |=> $stable(addrAccept))
        else $error("address verdict moved");
    a_fifo_clear_cause: assert property (fifoClear |-> $past(crcDone && !crcOk && crcCheckEnable))
        else $error("clear without failure");
    a_pass_no_clear: assert property (crcDone && crcOk |=> !fifoClear)
        else $error("clear on pass");
    a_data_out_follow: assert property (rxDataOutValid == $past(rxDataValid))
        else $error("data strobe late");
    a_clk_off_low: assert property (!clkOutEnable ##1 !clkOutEnable |-> !clkOut)
        else $error("clock out while off");
    a_bypass_low: assert property (clkOutBypass ##1 clkOutBypass |-> !clkOut)
        else $error("clock out in bypass");
    a_miso_idle_off: assert property (cfgSelN [*4] |-> cfgMisoOeN)
        else $error("miso driven idle");

    c_fifo_clear: cover property (fifoClear);
    c_var_len_ok: cover property (rxLenValid && !fixedLength ##1 lengthOk);
    c_clk_bypass: cover property (clkOutBypass);
endmodule

bind rxpc_config_regs rxpc_config_regs_chk u_chk (.*);

// ==== rxpc_config_regs_tb_top.sv ====
// self-checking bench for the receiver configuration register block
`timescale 1ns/10ps

module rxpc_config_regs_tb_top;
    typedef struct packed {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} rxpc_row_s;
    logic        core_clk, sys_rst, cfgSelN, cfgSck, cfgMosi, cfgMiso, cfgMisoOeN, misoWire, idlePat;
    logic        subChipTick, rxStart, rxAddrValid, rxLenValid, rxDataValid, crcDone, crcOk;
    logic        thrDecPulse, avgSlowCutoff, clkOut, clkOutEnable, clkOutBypass, manchesterEnable;
    logic        fixedLength, lengthOk, addrAccept, rxDataOutValid, crcCheckEnable, fifoClear;
    logic [1:0]  syncSize;
    logic [3:0]  thrStepHalfDb;
    logic [6:0]  lengthLimit;
    logic [7:0]  rssiLevel, rxAddr, rxLen, rxData, rxDataOut, q;
    logic [31:0] syncPattern, syncMask;
    int          err_count, num_checks, cyc, n;
    logic [3:0]  steps [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
    rxpc_row_s   rows [19] = '{
        '{1'b0, 5'h13, 8'h00, 8'h07}, '{1'b0, 5'h1b, 8'h00, 8'hbc}, '{1'b0, 5'h1e, 8'h00, 8'h48},
        '{1'b0, 5'h1c, 8'h00, 8'h00}, '{1'b0, 5'h1d, 8'h00, 8'h00}, '{1'b0, 5'h1f, 8'h00, 8'h00},
        '{1'b0, 5'h15, 8'h00, 8'h00}, '{1'b0, 5'h16, 8'h00, 8'h00}, '{1'b1, 5'h14, 8'hff, 8'h42},
        '{1'b1, 5'h1a, 8'h55, 8'h00}, '{1'b1, 5'h16, 8'ha5, 8'ha5}, '{1'b1, 5'h17, 8'h5a, 8'h5a},
        '{1'b1, 5'h18, 8'h3c, 8'h3c}, '{1'b1, 5'h19, 8'hc3, 8'hc3}, '{1'b1, 5'h1d, 8'h5a, 8'h5a},
        '{1'b1, 5'h1c, 8'h85, 8'h85}, '{1'b1, 5'h1f, 8'hc0, 8'hc0}, '{1'b1, 5'h1e, 8'hdf, 8'hde},
        '{1'b1, 5'h1b, 8'h8c, 8'h8c}};

    assign misoWire = cfgMisoOeN ? idlePat : cfgMiso;

    rxpc_config_regs DUT (.*);
    rxpc_host_model HOST (.core_clk(core_clk), .cfgSelN(cfgSelN), .cfgSck(cfgSck), .cfgMosi(cfgMosi),
                          .cfgMiso(misoWire));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        idlePat <= ~idlePat;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end

    // ==========
    // tasks
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        HOST.xfer(1'b1, a, 8'h00, q);
        chk($sformatf("reg %h", a), q, e);
    endtask

    // k: 0 address, 1 length, 2 data, 3 crc result, 4 packet start
    task automatic pkt(input int k, input logic [7:0] v, input logic ok);
        @(posedge core_clk);
        {rxAddr, rxLen, rxData} <= {3{v}};
        crcOk <= ok;
        rxAddrValid <= (k == 0);
        rxLenValid <= (k == 1);
        rxDataValid <= (k == 2);
        crcDone <= (k == 3);
        rxStart <= (k == 4);
        @(posedge core_clk);
        {rxAddrValid, rxLenValid, rxDataValid, crcDone, rxStart} <= 5'h00;
        #1;
    endtask

    task automatic af(input logic [1:0] f, input logic [7:0] a, input logic e);
        HOST.xfer(1'b0, 5'h1e, {5'b11011, f, 1'b0}, q);
        pkt(0, a, 1'b0);
        chk($sformatf("accept %h %h", f, a), addrAccept, e);
    endtask

    task automatic halfp(input int e);
        n = 0;
        @(posedge clkOut);
        while (clkOut === 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("clkout half period", n, e);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========
    // main sequence
    initial begin
        {sys_rst, idlePat, cyc, err_count, num_checks} = {2'b10, 96'h0};
        {rxStart, rxAddrValid, rxLenValid, rxDataValid, crcDone, crcOk} = 6'h00;
        {rxAddr, rxLen, rxData} = 24'h0;
        rssiLevel = 8'h42;
        syncSize = 2'h3;
        subChipTick = 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        halfp(15);
        foreach (rows[i]) begin
            if (rows[i].w) HOST.xfer(1'b0, rows[i].a, rows[i].d, q);
            rd(rows[i].a, rows[i].e);
        end
        chk("sync pattern", syncPattern, 32'ha55a3cc3);
        chk("manchester", {manchesterEnable, lengthLimit}, 8'h85);
        chk("format", {fixedLength, crcCheckEnable, clkOutEnable}, 3'h3);
        halfp(3);
        for (int i = 0; i < 4; i++) begin
            syncSize <= i[1:0];
            repeat (3) @(posedge core_clk);
            chk("sync mask", syncMask, {8'hff, {8{i != 0}}, {8{i[1]}}, {8{i == 3}}});
        end
        syncSize <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            HOST.xfer(1'b0, 5'h15, {i[2:0], i[2:0], {2{i[0]}}}, q);
            repeat (130) @(posedge core_clk);
            n = 0;
            repeat (256) begin
                @(posedge core_clk);
                #1;
                if (thrDecPulse === 1'b1) n++;
            end
            chk("threshold step", thrStepHalfDb, steps[i]);
            chk("decrement count", n, (i < 4) ? (16 >> i) : (32 << (i - 4)));
            chk("slow cutoff", avgSlowCutoff, i[0]);
        end
        af(2'h3, 8'h5a, 1'b1);
        af(2'h3, 8'h00, 1'b1);
        af(2'h3, 8'hff, 1'b1);
        af(2'h3, 8'h33, 1'b0);
        af(2'h1, 8'h00, 1'b0);
        af(2'h2, 8'hff, 1'b0);
        af(2'h2, 8'h00, 1'b1);
        af(2'h0, 8'h33, 1'b1);
        pkt(1, 8'h05, 1'b0);
        chk("var length at max", lengthOk, 1'b1);
        pkt(1, 8'h06, 1'b0);
        chk("var length over max", lengthOk, 1'b0);
        HOST.xfer(1'b0, 5'h1e, 8'h5e, q);
        pkt(1, 8'h04, 1'b0);
        chk("fixed length short", {fixedLength, lengthOk}, 2'h2);
        pkt(4, 8'h00, 1'b0);
        pkt(2, 8'h00, 1'b0);
        chk("dewhitened byte", {rxDataOutValid, rxDataOut}, 9'h1ff);
        HOST.xfer(1'b0, 5'h1e, 8'h4e, q);
        pkt(2, 8'h3c, 1'b0);
        chk("plain byte", {rxDataOutValid, rxDataOut}, 9'h13c);
        pkt(3, 8'h00, 1'b0);
        chk("kept fifo", fifoClear, 1'b0);
        rd(5'h1e, 8'h4e);
        HOST.xfer(1'b0, 5'h1f, 8'h40, q);
        pkt(3, 8'h00, 1'b0);
        chk("auto clear", fifoClear, 1'b1);
        pkt(3, 8'h00, 1'b1);
        chk("pass no clear", fifoClear, 1'b0);
        rd(5'h1e, 8'h4f);
        HOST.xfer(1'b0, 5'h1e, 8'h46, q);
        pkt(3, 8'h00, 1'b0);
        chk("check off", {crcCheckEnable, fifoClear}, 2'h0);
        HOST.xfer(1'b0, 5'h1b, 8'h0c, q);
        chk("clkout off", {clkOutEnable, clkOut}, 2'h0);
        HOST.xfer(1'b0, 5'h1b, 8'h80, q);
        chk("clkout bypass", {clkOutEnable, clkOutBypass, clkOut}, 3'h6);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("after reset", {syncPattern, clkOutEnable}, 33'h1);
        end_sim();
    end
endmodule
